// ===== spc_consts.svh
// constants for the strap and shared serial pin configuration block
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// ------------------------------------------------------------
// synchroniser and strap timing
// ------------------------------------------------------------
`define SPC_SYNC_STAGES    2
`define SPC_SYNC_RST       8'hFF
`define SPC_STRAP_WAIT     2'h3

// ------------------------------------------------------------
// strap encodings
// ------------------------------------------------------------
`define SPC_MODE_EEPROM    1'h1
`define SPC_FPM_ENABLED    1'h0

// ------------------------------------------------------------
// bit positions in the synchronised input vector
// ------------------------------------------------------------
`define SPC_BIT_OC_LO      0
`define SPC_BIT_OC_P4      3
`define SPC_BIT_FPM        4
`define SPC_BIT_MODE       5
`define SPC_BIT_SDA        6
`define SPC_BIT_SCL        7
`define SPC_SYNC_W         8

`endif

// ===== spc_pkg.sv
// types for the strap and shared serial pin configuration block
package spc_pkg;

  // strap capture sequence after reset release
  typedef enum logic [1:0] {
    SPC_ST_WAIT   = 2'b00,
    SPC_ST_SAMPLE = 2'b01,
    SPC_ST_RUN    = 2'b10
  } spc_state_e;

endpackage

// ===== spc_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none

module spc_sync #(
  parameter int          WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // spc_sync

`default_nettype wire

// ===== spc_pin_config.sv
// strap capture, shared serial pin routing and overcurrent sensing
//
// Functional notes
// R1: port-4 overcurrent input is active low
// R2: ganged mode accepts overcurrent on any input
// R3: mode strap at reset: 1 EEPROM, 0 SMBus
// R4: EEPROM mode: pins are controller clock/data
// R5: SMBus mode: pins are target, host drives
// R6: status enable drives suspend state on strap pin
// R7: power strap 0 enables switching and overcurrent
// R8: power strap 1 disables and ignores overcurrent
// R9: SMBus address bit 1 from power strap
// R10: sampled straps hold until next reset
`timescale 1ns/1ps
`default_nettype none
`include "spc_consts.svh"

module spc_pin_config (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // strap pins
  input  wire logic       serial_mode_strap_n,
  output var  logic       suspend_pin_out,
  output var  logic       suspend_pin_oe,
  input  wire logic       full_power_mgmt_strap_n,
  // overcurrent pins, ports 1 to 3 and port 4
  input  wire logic [2:0] port_overcurrent_n,
  input  wire logic       port4_overcurrent_n,
  // shared serial pins, open drain
  input  wire logic       scl_in,
  output var  logic       scl_out,
  output var  logic       scl_oe,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  // core controls
  input  wire logic       status_output_enable,
  input  wire logic       upstream_suspended,
  input  wire logic       ganged_enable,
  input  wire logic       eep_scl_low,
  input  wire logic       eep_sda_low,
  input  wire logic       tgt_scl_low,
  input  wire logic       tgt_sda_low,
  // core status
  output var  logic       straps_valid,
  output var  logic       eeprom_mode,
  output var  logic       smbus_target_addr_strap_bit1,
  output var  logic       power_switch_enable,
  output var  logic [3:0] overcurrent_port,
  output var  logic       overcurrent_ganged,
  output var  logic       scl_level,
  output var  logic       sda_level,
  output var  logic       scl_rise,
  output var  logic       scl_fall
);

  // ------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------
  logic [`SPC_SYNC_W-1:0] sync_v;

  spc_sync #(
    .WIDTH   (`SPC_SYNC_W),
    .RST_VAL (`SPC_SYNC_RST)
  ) u_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in ({scl_in, sda_in, serial_mode_strap_n, full_power_mgmt_strap_n,
                port4_overcurrent_n, port_overcurrent_n}),
    .sync_out (sync_v)
  );

  wire       mode_s = sync_v[`SPC_BIT_MODE];
  wire       fpm_s  = sync_v[`SPC_BIT_FPM];
  wire       scl_s  = sync_v[`SPC_BIT_SCL];
  wire       sda_s  = sync_v[`SPC_BIT_SDA];
  wire [3:0] oc_n_s = sync_v[`SPC_BIT_OC_P4:`SPC_BIT_OC_LO];

  // ------------------------------------------------------------
  // strap capture sequence
  // ------------------------------------------------------------
  spc_pkg::spc_state_e state_r;
  spc_pkg::spc_state_e state_nxt;
  logic [1:0]          wait_r;
  logic                mode_r;
  logic                fpm_r;
  logic                pse_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      spc_pkg::SPC_ST_WAIT: begin
        if (wait_r == `SPC_STRAP_WAIT) state_nxt = spc_pkg::SPC_ST_SAMPLE;
      end
      spc_pkg::SPC_ST_SAMPLE: state_nxt = spc_pkg::SPC_ST_RUN;
      spc_pkg::SPC_ST_RUN:    state_nxt = spc_pkg::SPC_ST_RUN;
      default:                state_nxt = spc_pkg::SPC_ST_WAIT;
    endcase
  end

  wire sample_now = (state_r == spc_pkg::SPC_ST_SAMPLE);
  wire running    = (state_r == spc_pkg::SPC_ST_RUN);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= spc_pkg::SPC_ST_WAIT;
      wait_r  <= 2'h0;
    end else begin
      state_r <= state_nxt;
      wait_r  <= (wait_r == `SPC_STRAP_WAIT) ? wait_r : wait_r + 2'h1;
    end
  end

  // straps are taken once, then frozen until reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= 1'h1;
      fpm_r  <= 1'h1;
      pse_r  <= 1'h0;
    end else if (sample_now) begin // see R3 see R10
      mode_r <= mode_s;
      fpm_r  <= fpm_s;
      pse_r  <= (fpm_s == `SPC_FPM_ENABLED); // see R7 see R8
    end
  end

  wire eeprom_sel = running && (mode_r == `SPC_MODE_EEPROM);   // see R3
  wire smbus_sel  = running && (mode_r != `SPC_MODE_EEPROM);
  wire pwr_en     = running && (fpm_r == `SPC_FPM_ENABLED);    // see R7 see R8

  // ------------------------------------------------------------
  // shared serial pin routing
  // ------------------------------------------------------------
  wire scl_drive = (eeprom_sel & eep_scl_low) | (smbus_sel & tgt_scl_low); // see R4 see R5
  wire sda_drive = (eeprom_sel & eep_sda_low) | (smbus_sel & tgt_sda_low); // see R4 see R5

  logic scl_oe_r;
  logic sda_oe_r;
  logic scl_prev_r;
  logic sda_lvl_r;
  logic rise_r;
  logic fall_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_oe_r   <= 1'h0;
      sda_oe_r   <= 1'h0;
      scl_prev_r <= 1'h1;
      sda_lvl_r  <= 1'h1;
      rise_r     <= 1'h0;
      fall_r     <= 1'h0;
    end else begin
      scl_oe_r   <= scl_drive;
      sda_oe_r   <= sda_drive;
      scl_prev_r <= scl_s;
      sda_lvl_r  <= sda_s;
      rise_r     <= scl_s & ~scl_prev_r;
      fall_r     <= ~scl_s & scl_prev_r;
    end
  end

  // ------------------------------------------------------------
  // suspend status on the mode strap pin
  // ------------------------------------------------------------
  logic susp_out_r;
  logic susp_oe_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      susp_out_r <= 1'h0;
      susp_oe_r  <= 1'h0;
    end else begin
      susp_oe_r  <= running & status_output_enable; // see R6
      susp_out_r <= running & upstream_suspended;   // see R6
    end
  end

  // ------------------------------------------------------------
  // overcurrent sensing, one stage per port
  // ------------------------------------------------------------
  wire [3:0] oc_hit;
  logic [3:0] oc_r;
  logic       oc_gang_r;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_oc
      assign oc_hit[gi] = pwr_en & ~oc_n_s[gi]; // see R1 see R8
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) oc_r[gi] <= 1'h0;
        else       oc_r[gi] <= oc_hit[gi];
      end
    end
  endgenerate

  // ganged: whichever input is wired counts for all ports
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) oc_gang_r <= 1'h0;
    else       oc_gang_r <= ganged_enable & (|oc_hit); // see R2
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic valid_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) valid_r <= 1'h0;
    else       valid_r <= sample_now | valid_r;
  end

  assign suspend_pin_out              = susp_out_r;
  assign suspend_pin_oe               = susp_oe_r;
  assign scl_out                      = 1'h0;
  assign sda_out                      = 1'h0;
  assign scl_oe                       = scl_oe_r;
  assign sda_oe                       = sda_oe_r;
  assign straps_valid                 = valid_r;
  assign eeprom_mode                  = mode_r;
  assign smbus_target_addr_strap_bit1 = fpm_r;   // see R9
  assign power_switch_enable          = pse_r;
  assign overcurrent_port             = oc_r;
  assign overcurrent_ganged           = oc_gang_r;
  assign scl_level                    = scl_prev_r;
  assign sda_level                    = sda_lvl_r;
  assign scl_rise                     = rise_r;
  assign scl_fall                     = fall_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_mode_capture: assert property (sample_now |=> mode_r == $past(mode_s)) // see R3
    else $error("mode strap not captured");
  a_straps_hold: assert property (running |=> $stable(mode_r) && $stable(fpm_r)) // see R10
    else $error("strap value changed after capture");
  a_addr_bit1: assert property (sample_now |=> ##1 smbus_target_addr_strap_bit1 == $past(fpm_s, 2)) // see R9
    else $error("address bit 1 differs from power strap");
  a_pwr_enable: assert property (sample_now |=> power_switch_enable == !$past(fpm_s)) // see R7
    else $error("power switch enable wrong polarity");
  a_oc_ignored: assert property (!pwr_en |=> overcurrent_port == 4'h0 && !overcurrent_ganged) // see R8
    else $error("overcurrent reported while ignored");
  a_oc_port4_low: assert property (pwr_en && !oc_n_s[3] |=> overcurrent_port[3]) // see R1
    else $error("port 4 low level not flagged");
  a_oc_port4_high: assert property (oc_n_s[3] |=> !overcurrent_port[3]) // see R1
    else $error("port 4 flagged while high");
  a_ganged_any: assert property (pwr_en && ganged_enable && oc_n_s != 4'hF |=> overcurrent_ganged) // see R2
    else $error("ganged overcurrent missed");
  a_scl_eeprom: assert property (eeprom_sel && eep_scl_low |=> scl_oe) // see R4
    else $error("eeprom clock not driven");
  a_sda_target: assert property (smbus_sel |=> sda_oe == $past(tgt_sda_low)) // see R5
    else $error("target data drive mismatch");
  a_suspend_out: assert property (running && status_output_enable // see R6
    |=> suspend_pin_oe && suspend_pin_out == $past(upstream_suspended))
    else $error("suspend status not driven");
  a_no_drive_early: assert property (!running |=> !suspend_pin_oe && !scl_oe && !sda_oe)
    else $error("pin driven before straps captured");

  c_eeprom_mode: cover property (sample_now ##1 eeprom_mode);
  c_smbus_mode: cover property (sample_now ##1 !eeprom_mode);
  c_ganged_oc: cover property (overcurrent_ganged && !overcurrent_port[3]);
  c_suspend_on: cover property (suspend_pin_oe && suspend_pin_out);

endmodule // spc_pin_config

`default_nettype wire

// ===== spc_serial_host.sv
// model of the external serial host on the shared clock and data pins
`timescale 1ns/1ps
`default_nettype none

module spc_serial_host #(
  parameter int N_CLK = 8
) (
  // frame control
  input  wire logic go,
  output var  logic busy,
  // shared pins, open drain
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output wire logic scl_in,
  output wire logic sda_in
);
  logic host_scl = 1'h1;

  initial busy = 1'h0;

  // host owns the frame: clock stands high outside it, data held low inside it
  always @(posedge go) begin
    busy = 1'h1;
    repeat (N_CLK) begin
      #24 host_scl = 1'h0;
      #24 host_scl = 1'h1;
    end
    busy = 1'h0;
  end

  // wired-and of every party pulling the pin
  assign scl_in = host_scl & ~scl_oe;
  assign sda_in = ~busy & ~sda_oe;
endmodule // spc_serial_host

`default_nettype wire

// ===== spc_pin_config_tb.sv
// self-checking bench for the strap and shared serial pin block
`timescale 1ns/1ps
`default_nettype none

module spc_pin_config_tb;
  logic       ref_clk = 1'h0;
  logic       nrst = 1'h0;
  logic       serial_mode_strap_n = 1'h1;
  logic       full_power_mgmt_strap_n = 1'h0;
  logic [2:0] port_overcurrent_n = 3'h7;
  logic       port4_overcurrent_n = 1'h1;
  logic       status_output_enable = 1'h0;
  logic       upstream_suspended = 1'h0;
  logic       ganged_enable = 1'h0;
  logic       eep_scl_low = 1'h0, eep_sda_low = 1'h0, tgt_scl_low = 1'h0, tgt_sda_low = 1'h0;
  logic       go = 1'h0;
  wire        busy, scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, suspend_pin_out, suspend_pin_oe;
  wire        straps_valid, eeprom_mode, smbus_target_addr_strap_bit1, power_switch_enable;
  wire  [3:0] overcurrent_port;
  wire        overcurrent_ganged, scl_level, sda_level, scl_rise, scl_fall;
  int         n_mismatch = 0, cmp_count = 0, n_rise = 0, n_fall = 0, i;

  always #2 ref_clk = ~ref_clk;

  spc_pin_config uut (.ref_clk, .nrst, .serial_mode_strap_n, .suspend_pin_out, .suspend_pin_oe,
    .full_power_mgmt_strap_n, .port_overcurrent_n, .port4_overcurrent_n, .scl_in, .scl_out, .scl_oe,
    .sda_in, .sda_out, .sda_oe, .status_output_enable, .upstream_suspended, .ganged_enable,
    .eep_scl_low, .eep_sda_low, .tgt_scl_low, .tgt_sda_low, .straps_valid, .eeprom_mode,
    .smbus_target_addr_strap_bit1, .power_switch_enable, .overcurrent_port, .overcurrent_ganged,
    .scl_level, .sda_level, .scl_rise, .scl_fall);

  spc_serial_host #(.N_CLK(8)) host (.go, .busy, .scl_oe, .sda_oe, .scl_in, .sda_in);

  always @(posedge ref_clk) begin
    if (scl_rise === 1'h1) n_rise++;
    if (scl_fall === 1'h1) n_fall++;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic boot(input logic m, input logic f);
    nrst = 1'h0;
    serial_mode_strap_n = m;
    full_power_mgmt_strap_n = f;
    cyc(5);
    chk({straps_valid, scl_oe, sda_oe, suspend_pin_oe}, 4'h0, "reset state");
    nrst = 1'h1;
    for (i = 0; i < 20 && straps_valid !== 1'h1; i++) cyc(1);
    if (i == 20) begin
      n_mismatch++;
      summarize();
    end
    chk(4'(i), 4'h5, "capture delay");
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    boot(1'h1, 1'h0);
    chk({1'h0, eeprom_mode, smbus_target_addr_strap_bit1, power_switch_enable}, 4'h5, "straps");
    serial_mode_strap_n = 1'h0;
    full_power_mgmt_strap_n = 1'h1;
    cyc(4);
    chk({1'h0, eeprom_mode, smbus_target_addr_strap_bit1, power_switch_enable}, 4'h5, "held");
    eep_scl_low = 1'h1;
    tgt_sda_low = 1'h1;
    cyc(1);
    chk({scl_out, sda_out, scl_oe, sda_oe}, 4'h2, "eeprom scl");
    eep_scl_low = 1'h0;
    tgt_sda_low = 1'h0;
    eep_sda_low = 1'h1;
    cyc(1);
    chk({2'h0, scl_oe, sda_oe}, 4'h1, "eeprom sda");
    eep_sda_low = 1'h0;
    port4_overcurrent_n = 1'h0;
    ganged_enable = 1'h1;
    cyc(3);
    chk(overcurrent_port, 4'h8, "port4 oc");
    chk({3'h0, overcurrent_ganged}, 4'h1, "ganged p4");
    port4_overcurrent_n = 1'h1;
    port_overcurrent_n = 3'h6;
    cyc(3);
    chk(overcurrent_port, 4'h1, "port1 oc");
    chk({3'h0, overcurrent_ganged}, 4'h1, "ganged p1");
    ganged_enable = 1'h0;
    cyc(2);
    chk({3'h0, overcurrent_ganged}, 4'h0, "ganged off");
    port_overcurrent_n = 3'h7;
    status_output_enable = 1'h1;
    upstream_suspended = 1'h1;
    cyc(1);
    chk({2'h0, suspend_pin_oe, suspend_pin_out}, 4'h3, "suspended");
    upstream_suspended = 1'h0;
    cyc(1);
    chk({2'h0, suspend_pin_oe, suspend_pin_out}, 4'h2, "awake");
    status_output_enable = 1'h0;
    cyc(1);
    chk({3'h0, suspend_pin_oe}, 4'h0, "status off");
    $display("test eeprom mode done");

    boot(1'h0, 1'h1);
    chk({1'h0, eeprom_mode, smbus_target_addr_strap_bit1, power_switch_enable}, 4'h2, "straps");
    port4_overcurrent_n = 1'h0;
    port_overcurrent_n = 3'h0;
    ganged_enable = 1'h1;
    cyc(4);
    chk({overcurrent_ganged, overcurrent_port[2:0]}, 4'h0, "oc ignored");
    chk(overcurrent_port, 4'h0, "oc ignored");
    port4_overcurrent_n = 1'h1;
    port_overcurrent_n = 3'h7;
    tgt_scl_low = 1'h1;
    eep_sda_low = 1'h1;
    cyc(1);
    chk({2'h0, scl_oe, sda_oe}, 4'h2, "target scl");
    tgt_scl_low = 1'h0;
    eep_sda_low = 1'h0;
    tgt_sda_low = 1'h1;
    eep_scl_low = 1'h1;
    cyc(1);
    chk({2'h0, scl_oe, sda_oe}, 4'h1, "target sda");
    tgt_sda_low = 1'h0;
    eep_scl_low = 1'h0;
    // let the edge pulses from the short clock pull die out before counting
    cyc(5);
    n_rise = 0;
    n_fall = 0;
    go = 1'h1;
    cyc(6);
    chk({3'h0, sda_level}, 4'h0, "host holds data");
    for (i = 0; i < 300 && busy !== 1'h0; i++) cyc(1);
    if (i == 300) begin
      n_mismatch++;
      summarize();
    end
    cyc(5);
    chk(4'(n_rise), 4'h8, "host clock rises");
    chk(4'(n_fall), 4'h8, "host clock falls");
    chk({2'h0, scl_level, sda_level}, 4'h3, "idle pins");
    go = 1'h0;
    $display("test smbus mode done");
    summarize();
  end
endmodule // spc_pin_config_tb

`default_nettype wire
